// File: pkg/decode_pkg.sv
// Constants for the two-word instruction decoder and address generator
package decode_pkg;
  // Word and address widths
  localparam int WORD_W = 8;
  localparam int ADDR_W = 12;
  localparam int TAG_W = 4;
  // First word field positions
  localparam int FUNC_LSB = 0;
  localparam int FUNC_W = 6;
  localparam int SEL_LSB = 6;
  localparam int SEL_W = 2;
  // Function codes (octal 20, 21, 22, 25)
  localparam logic [5:0] FC_LOAD_IMMEDIATE = 6'h10;
  localparam logic [5:0] FC_LOAD_DIRECT = 6'h11;
  localparam logic [5:0] FC_LOAD_INDIRECT = 6'h12;
  localparam logic [5:0] FC_LOAD_COMPLEMENT_DIRECT = 6'h15;
  // Storage cycle timing
  localparam int CLK_NS = 10;
  localparam int STORAGE_CYCLE_NS = 4000;
  localparam int CYCLE_CLKS = (STORAGE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  // Wishbone register byte addresses
  localparam logic [7:0] REG_ACC = 8'h00;
  localparam logic [7:0] REG_TAG1 = 8'h04;
  localparam logic [7:0] REG_TAG2 = 8'h08;
  localparam logic [7:0] REG_TAG3 = 8'h0C;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_CYCLES = 8'h1C;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] TAG_RST = 4'h0;
  localparam logic [11:0] PC_RST = 12'h000;
  // Control register bits
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STEP_BIT = 1;
  // Status register bits
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ILLEGAL_BIT = 1;
  localparam int STAT_SKIPPED_BIT = 2;
  // Sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_FETCH1 = 7'h02,
    ST_FETCH2 = 7'h04,
    ST_INDIR = 7'h08,
    ST_OPERAND = 7'h10,
    ST_WAIT = 7'h20,
    ST_DONE = 7'h40
  } seq_state_t;
endpackage : decode_pkg

// File: rtl/cycle_timer.sv
// Storage cycle timer: one pulse per elapsed 4 us machine cycle
`timescale 1ns/100ps
`default_nettype none
module cycle_timer (
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  input wire logic START_IN,
  output logic TICK_OUT
);
  // Clock counter within one machine cycle
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  // Last count of a cycle
  localparam logic [9:0] LAST = 10'(decode_pkg::CYCLE_CLKS - 1);
  assign TICK_OUT = (cnt_q == LAST);
  assign cnt_d = (START_IN || TICK_OUT) ? 10'h000 : cnt_q + 10'h001;
  // Free counting, restarted when an instruction leaves idle
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : cycle_timer
`default_nettype wire

// File: rtl/instr_decoder.sv
// Two-word instruction decoder, address generator and load group
// What this block does
// - Fetch each instruction from P and P+1.
// - Function low six bits, selector top two.
// - Immediate mode uses second word, no tag.
// - Selector zero: address upper bits zero.
// - Selector 1-3: tag gives upper four bits.
// - Indirect reads pointer from lowest 256 words.
// - Indirect upper bits from tag, zero if none.
// - Indirect selector is first-word bits 6,7.
// - Immediate load copies word, continues P+2.
// - Direct load reads formed 12-bit address.
// - Indirect load reads operand at formed address.
// - Complement load inverts word, 12 us, P+2.
// - After immediate instruction, next is P+2.
// - Machine cycle of 4 us counts time.
// - Sense jump three cycles taken, else two.
// - Three 4-bit tag registers, numbered 1-3.
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module instr_decoder (
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Core memory port: the address and request stand for a whole
  // reference, and the word is sampled at its last clock
  output logic MEM_REQ_OUT,
  output logic [11:0] MEM_ADDR_OUT,
  input wire logic [7:0] MEM_DATA_IN,
  // Sense jump outcome for cycle accounting, sampled at the end of the
  // second fetch
  input wire logic JUMP_TAKEN_IN,
  output logic BUSY_OUT
);

  // Architectural state. Every register here is cleared by the
  // asynchronous reset, so the tag registers come up naming bank zero
  // and the first instruction is fetched from address zero.
  logic [7:0] acc_q;
  logic [11:0] pc_q;
  logic [3:0] tag_q [1:3];
  logic [7:0] word1_q;
  logic [7:0] word2_q;
  logic [7:0] ptr_q;
  logic [7:0] cycles_q;
  logic run_q;
  logic step_q;
  logic illegal_q;
  logic skipped_q;
  logic ack_q;
  logic [31:0] rdata_q;
  decode_pkg::seq_state_t state_q;
  decode_pkg::seq_state_t state_d;

  // Storage cycle pulse. One machine cycle lasts a whole storage reference;
  // the timer is restarted when an instruction leaves idle so that the
  // first reference gets its full length.
  logic tick;
  logic start_mem;
  // One timer serves every reference of the sequencer
  cycle_timer u_timer (
    .CLK_SYS_IN(CLK_SYS_IN),
    .NRST_IN(NRST_IN),
    .START_IN(start_mem),
    .TICK_OUT(tick)
  );

  // Field split of the first word: the function sits in the low six bits
  // and the tag-register selector in the top two.
  wire [5:0] func = word1_q[decode_pkg::FUNC_LSB +: decode_pkg::FUNC_W];
  wire [1:0] sel = word1_q[decode_pkg::SEL_LSB +: decode_pkg::SEL_W];

  // Tag contribution, zero when no tag register is named. Selector zero
  // must not index the tag array, which has no entry zero.
  wire [3:0] tag_hi = (sel == 2'b00) ? 4'h0 : tag_q[sel];

  // Instruction class decode. Only the load group is executed here; every
  // other code is fetched, timed and stepped over.
  wire is_imm = (func == decode_pkg::FC_LOAD_IMMEDIATE);
  wire is_dir = (func == decode_pkg::FC_LOAD_DIRECT);
  wire is_ind = (func == decode_pkg::FC_LOAD_INDIRECT);
  wire is_lcm = (func == decode_pkg::FC_LOAD_COMPLEMENT_DIRECT);
  wire is_load = is_imm | is_dir | is_ind | is_lcm;

  // Effective operand addresses. The pointer of indirect mode always lies
  // in the lowest 256 words, whatever the selector says.
  wire [11:0] dir_addr = {tag_hi, word2_q};
  wire [11:0] ind_ptr_addr = {4'h0, word2_q};
  wire [11:0] ind_addr = {tag_hi, ptr_q};
  wire [11:0] pc_next = pc_q + 12'h002;

  // Class decode seen by the sequencer at the end of the second fetch.
  // The first word is already latched then, so these are plain copies of
  // the fields above; they are kept apart so the branch reads clearly.
  wire [5:0] func2 = word1_q[5:0];  // Function field of the held first word
  wire is_imm2 = (func2 == decode_pkg::FC_LOAD_IMMEDIATE);  // No memory operand
  wire is_ind2 = (func2 == decode_pkg::FC_LOAD_INDIRECT);  // Pointer read needed
  wire is_load_d2 = is_load;  // Any load group code

  // Sense jumps (octal 60-64) take a third cycle when taken.
  // Only the cycle accounting is modelled; the jump target is not used,
  // so the program counter still steps by two.
  wire is_jump = (func >= 6'h30) && (func <= 6'h34);  // Sense jump class
  wire jump_wait = is_jump && JUMP_TAKEN_IN;

  // Bus decode, declared here because the register processes below use it.
  // A request is taken once; the held strobe during the ack cycle is masked.
  wire [7:0] wb_adr = WB_ADR_IN;  // Byte address of the register
  wire wb_req = WB_CYC_IN && WB_STB_IN && !ack_q;  // New request this cycle
  wire wb_wr = wb_req && WB_WE_IN && WB_SEL_IN[0];  // Write with lane 0 enabled

  // Memory address per state. The address is held for the whole reference,
  // since it depends on registers that only change at its last clock.
  always_comb begin
    unique case (state_q)
      decode_pkg::ST_FETCH1: MEM_ADDR_OUT = pc_q;
      decode_pkg::ST_FETCH2: MEM_ADDR_OUT = pc_q + 12'h001;
      decode_pkg::ST_INDIR: MEM_ADDR_OUT = ind_ptr_addr;
      decode_pkg::ST_OPERAND: MEM_ADDR_OUT = is_ind ? ind_addr : dir_addr;
      default: MEM_ADDR_OUT = pc_q;
    endcase
  end

  // Memory is read across states that hold a storage reference
  wire in_mem_state = (state_q == decode_pkg::ST_FETCH1) | (state_q == decode_pkg::ST_FETCH2) |
                      (state_q == decode_pkg::ST_INDIR) | (state_q == decode_pkg::ST_OPERAND);
  assign MEM_REQ_OUT = in_mem_state;
  assign BUSY_OUT = (state_q != decode_pkg::ST_IDLE);

  // Timer restarts when an instruction starts; later references follow
  // back to back, each ending at the timer's last count.
  assign start_mem = (state_q == decode_pkg::ST_IDLE) && state_d != decode_pkg::ST_IDLE;

  // Sequencer next state: each memory state lasts one 4 us cycle.
  // Immediate loads end after the second fetch, direct loads need one
  // operand reference and indirect loads a pointer reference first.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      decode_pkg::ST_IDLE: begin
        if (run_q || step_q) begin
          state_d = decode_pkg::ST_FETCH1;
        end
      end
      decode_pkg::ST_FETCH1: begin
        if (tick) begin
          state_d = decode_pkg::ST_FETCH2;
        end
      end
      decode_pkg::ST_FETCH2: begin
        if (tick) begin
          if (is_load_d2) begin
            state_d = is_ind2 ? decode_pkg::ST_INDIR :
                      (is_imm2 ? decode_pkg::ST_DONE : decode_pkg::ST_OPERAND);
          end else begin
            state_d = jump_wait ? decode_pkg::ST_WAIT : decode_pkg::ST_DONE;
          end
        end
      end
      decode_pkg::ST_INDIR: begin
        if (tick) begin
          state_d = decode_pkg::ST_OPERAND;
        end
      end
      decode_pkg::ST_OPERAND: begin
        if (tick) begin
          state_d = decode_pkg::ST_DONE;
        end
      end
      decode_pkg::ST_WAIT: begin
        if (tick) begin
          state_d = decode_pkg::ST_DONE;
        end
      end
      decode_pkg::ST_DONE: state_d = decode_pkg::ST_IDLE;
      default: state_d = decode_pkg::ST_IDLE;
    endcase
  end

  // Operand value for the load group. Memory mode and indirect mode share
  // it; the complement is taken over all eight bits, so a loaded word and
  // its complement always differ in every bit.
  // Operand result for the load group
  wire [7:0] load_val = is_lcm ? ~MEM_DATA_IN : MEM_DATA_IN;

  // Sequencer and instruction registers. Each word is captured at the
  // last clock of its reference, when the memory word has settled.
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q <= decode_pkg::ST_IDLE;
      word1_q <= 8'h00;
      word2_q <= 8'h00;
      ptr_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q == decode_pkg::ST_FETCH1 && tick) begin
        word1_q <= MEM_DATA_IN;
      end
      if (state_q == decode_pkg::ST_FETCH2 && tick) begin
        word2_q <= MEM_DATA_IN;
      end
      if (state_q == decode_pkg::ST_INDIR && tick) begin
        ptr_q <= MEM_DATA_IN;
      end
    end
  end

  // Accumulator, program counter and machine cycle counter. The cycle
  // count restarts with each instruction and holds until the next one,
  // so software can read how long the last instruction took. Execution
  // results win over a bus write to the same register in one cycle.
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      acc_q <= decode_pkg::ACC_RST;
      pc_q <= decode_pkg::PC_RST;
      cycles_q <= 8'h00;
      illegal_q <= 1'b0;
      skipped_q <= 1'b0;
    end else begin
      if (tick && in_mem_state || tick && state_q == decode_pkg::ST_WAIT) begin
        cycles_q <= cycles_q + 8'h01;
      end else if (state_q == decode_pkg::ST_IDLE && state_d == decode_pkg::ST_FETCH1) begin
        cycles_q <= 8'h00;
      end
      if (state_q == decode_pkg::ST_FETCH2 && tick && is_imm2) begin
        acc_q <= MEM_DATA_IN;
      end else if (state_q == decode_pkg::ST_OPERAND && tick) begin
        acc_q <= load_val;
      end else if (wb_wr && wb_adr == decode_pkg::REG_ACC) begin
        acc_q <= WB_DAT_IN[7:0];
      end
      if (state_q == decode_pkg::ST_DONE) begin
        pc_q <= pc_next;
        skipped_q <= !is_load;
        illegal_q <= is_imm && (sel != 2'b00);
      end else if (wb_wr && wb_adr == decode_pkg::REG_PC) begin
        pc_q <= WB_DAT_IN[11:0];
      end
    end
  end

  // Read side of the register map. Unmapped addresses read as zero, and
  // the status word packs the last instruction's outcome above the busy bit.
  wire [31:0] status_word = {29'h0, skipped_q, illegal_q, BUSY_OUT};
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr)
      decode_pkg::REG_ACC: rd_mux = {24'h0, acc_q};
      decode_pkg::REG_TAG1: rd_mux = {28'h0, tag_q[1]};
      decode_pkg::REG_TAG2: rd_mux = {28'h0, tag_q[2]};
      decode_pkg::REG_TAG3: rd_mux = {28'h0, tag_q[3]};
      decode_pkg::REG_PC: rd_mux = {20'h0, pc_q};
      decode_pkg::REG_CTRL: rd_mux = {30'h0, step_q, run_q};
      decode_pkg::REG_STATUS: rd_mux = status_word;
      decode_pkg::REG_CYCLES: rd_mux = {24'h0, cycles_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus answer one cycle after the request, tag and control writes.
  // The step bit clears itself once the sequencer leaves idle, and a
  // write in the same cycle takes precedence over that clear.
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      run_q <= 1'b0;
      step_q <= 1'b0;
      tag_q[1] <= decode_pkg::TAG_RST;
      tag_q[2] <= decode_pkg::TAG_RST;
      tag_q[3] <= decode_pkg::TAG_RST;
    end else begin
      ack_q <= wb_req;
      rdata_q <= rd_mux;
      if (state_q == decode_pkg::ST_IDLE && step_q) begin
        step_q <= 1'b0;
      end
      if (wb_wr) begin
        if (wb_adr == decode_pkg::REG_TAG1) tag_q[1] <= WB_DAT_IN[3:0];
        if (wb_adr == decode_pkg::REG_TAG2) tag_q[2] <= WB_DAT_IN[3:0];
        if (wb_adr == decode_pkg::REG_TAG3) tag_q[3] <= WB_DAT_IN[3:0];
        if (wb_adr == decode_pkg::REG_CTRL) begin
          run_q <= WB_DAT_IN[decode_pkg::CTRL_RUN_BIT];
          step_q <= WB_DAT_IN[decode_pkg::CTRL_STEP_BIT];
        end
      end
    end
  end

  // Registered bus outputs
  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = rdata_q;
endmodule : instr_decoder
`default_nettype wire

// File: tb/instr_decoder_assertions.sv
// Checker on bus answers and storage reference timing
`timescale 1ns/100ps
`default_nettype none
module instr_decoder_assertions (
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_ACK_OUT,
  input wire logic MEM_REQ_OUT,
  input wire logic [11:0] MEM_ADDR_OUT,
  input wire logic BUSY_OUT
);
  logic [11:0] addr_q, busy_q; // Last address, clocks busy
  logic [9:0] ref_q; // Clocks on the current address
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);
  // Measure reference and instruction lengths
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      addr_q <= 12'h000;
      busy_q <= 12'h000;
      ref_q <= 10'h000;
    end else begin
      addr_q <= MEM_ADDR_OUT;
      busy_q <= BUSY_OUT ? busy_q + 12'h001 : 12'h000;
      ref_q <= (MEM_REQ_OUT && MEM_ADDR_OUT == addr_q) ? ref_q + 10'h001 : 10'h000;
    end
  end
  sequence s_take; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT; endsequence
  sequence s_pulse; WB_ACK_OUT ##1 !WB_ACK_OUT; endsequence
  ack_answer_a: assert property (s_take |=> s_pulse) else $error("ack late or long");
  ack_cause_a: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN))
    else $error("ack without request");
  ack_quiet_a: assert property (!WB_CYC_IN |=> !WB_ACK_OUT) else $error("stray ack");
  req_busy_a: assert property (MEM_REQ_OUT |-> BUSY_OUT) else $error("reference while idle");
  fetch_start_a: assert property ($rose(BUSY_OUT) |-> ##[0:2] MEM_REQ_OUT)
    else $error("no fetch");
  ref_length_a: assert property (MEM_REQ_OUT && $past(MEM_REQ_OUT) && MEM_ADDR_OUT != addr_q
    |-> ref_q >= 10'h18E) else $error("reference shorter than 4 us");
  two_fetch_a: assert property ($fell(BUSY_OUT) |-> $past(busy_q) >= 12'h316)
    else $error("instruction shorter than two references");
  busy_bound_a: assert property (busy_q < 12'h6A4) else $error("instruction too long");
endmodule : instr_decoder_assertions
bind instr_decoder instr_decoder_assertions u_chk (.CLK_SYS_IN, .NRST_IN, .WB_CYC_IN,
  .WB_STB_IN, .WB_ACK_OUT, .MEM_REQ_OUT, .MEM_ADDR_OUT, .BUSY_OUT);
`default_nettype wire

// File: tb/core_mem_model.sv
// Core memory answering the decoder's storage references
`timescale 1ns/100ps
`default_nettype none
module core_mem_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [11:0] addr_in,
  output logic [7:0] data_out
);
  logic [7:0] mem [4096]; // Eight-bit words, loaded by the bench
  logic [7:0] last_q = 8'h00; // Word shown last cycle
  // Idle lines flip each cycle so a stale word never matches
  assign data_out = req_in ? mem[addr_in] : ~last_q;
  // Remember the shown word
  always_ff @(posedge clk_in) begin
    last_q <= data_out;
  end
endmodule : core_mem_model
`default_nettype wire

// File: tb/two_word_instr_decode_addr_gen_tb.sv
// Bench stepping the decoder through the load group
`timescale 1ns/100ps
`default_nettype none
module two_word_instr_decode_addr_gen_tb;
  logic clk = 1'h0, nrst = 1'h0, cyc = 1'h0, we = 1'h0, jmp = 1'h0; // Driven bits
  logic [7:0] adr = 8'h00; // Register address
  logic [3:0] sel = 4'h0; // Byte lanes
  logic [31:0] wdat = 32'h0, rdat, q, cyc_lo; // Bus data, last read, untaken jump
  logic ack, req, busy; // Design answers
  logic [11:0] maddr; // Storage address
  logic [7:0] mdat; // Storage word
  int n_mismatch = 0, checked = 0, ticks = 0; // Tallies
  // Program and operands as address and word
  logic [19:0] img [25] = '{20'h00010, 20'h001FF, 20'h00250, 20'h00300, 20'h004D1, 20'h0057B,
    20'h00611, 20'h00744, 20'h00892, 20'h0098E, 20'h00A12, 20'h00BFF, 20'h00C55, 20'h00D10,
    20'h00E30, 20'h00F00, 20'h01030, 20'h01100, 20'hD7B1B, 20'h0445A, 20'h08EA6, 20'h7A6BF,
    20'h0FF21, 20'h02199, 20'h31055};
  logic [7:0] acc_x [9] = '{8'hFF, 8'h00, 8'h1B, 8'h5A, 8'hBF, 8'h99, 8'hAA, 8'hAA, 8'hAA};
  logic [31:0] len_x [7] = '{32'h2, 32'h2, 32'h3, 32'h3, 32'h4, 32'h4, 32'h3};
  instr_decoder u_dut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .WB_CYC_IN(cyc), .WB_STB_IN(cyc),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .MEM_REQ_OUT(req), .MEM_ADDR_OUT(maddr), .MEM_DATA_IN(mdat),
    .JUMP_TAKEN_IN(jmp), .BUSY_OUT(busy));
  core_mem_model u_mem (.clk_in(clk), .req_in(req), .addr_in(maddr), .data_out(mdat));
  // 100 MHz clock
  always #5 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    q = rdat;
    cyc <= 1'h0;
    we <= 1'h0;
    @(posedge clk);
  endtask : wb
  // Run one instruction and wait for its end
  task automatic step;
    wb(1'h1, decode_pkg::REG_CTRL, 32'h2, 4'hF);
    while (busy !== 1'h1) @(posedge clk);
    wb(1'h0, decode_pkg::REG_STATUS, 32'h0, 4'hF);
    chk(q[decode_pkg::STAT_BUSY_BIT], 1'h1);
    wb(1'h0, decode_pkg::REG_CTRL, 32'h0, 4'hF);
    chk(q, 32'h0);
    while (busy !== 1'h0) @(posedge clk);
  endtask : step
  // Verdict
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Cut a hang short
  always @(posedge clk) begin
    ticks++;
    if (ticks == 30000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    foreach (img[i]) begin
      u_mem.mem[img[i][19:8]] = img[i][7:0];
    end
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    wb(1'h0, decode_pkg::REG_TAG1, 32'h0, 4'hF);
    chk(q, {28'h0, decode_pkg::TAG_RST});
    wb(1'h1, decode_pkg::REG_TAG1, 32'h3, 4'hF);
    wb(1'h1, decode_pkg::REG_TAG2, 32'h7, 4'hF);
    wb(1'h1, decode_pkg::REG_TAG3, 32'hD, 4'hF);
    wb(1'h1, decode_pkg::REG_TAG1, 32'hF, 4'hE); // Lane 0 off: ignored
    wb(1'h0, decode_pkg::REG_TAG1, 32'h0, 4'hF);
    chk(q, 32'h3);
    wb(1'h0, decode_pkg::REG_TAG3, 32'h0, 4'hF);
    chk(q, 32'hD);
    wb(1'h0, 8'h20, 32'h0, 4'hF);
    chk(q, 32'h0);
    $display("Register test done");
    for (int i = 0; i < 9; i++) begin
      jmp <= (i == 8);
      step();
      wb(1'h0, decode_pkg::REG_ACC, 32'h0, 4'hF);
      chk(q, {24'h0, acc_x[i]});
      wb(1'h0, decode_pkg::REG_PC, 32'h0, 4'hF);
      chk(q, 2 * (i + 1));
      wb(1'h0, decode_pkg::REG_STATUS, 32'h0, 4'hF);
      chk(q[decode_pkg::STAT_ILLEGAL_BIT], i == 1);
      chk(q[decode_pkg::STAT_SKIPPED_BIT], i > 6);
      wb(1'h0, decode_pkg::REG_CYCLES, 32'h0, 4'hF);
      if (i < 7) chk(q, len_x[i]);
      if (i == 7) cyc_lo = q;
      if (i == 8) chk(q - cyc_lo, 32'h1);
      $display("Instruction test %0d done", i);
    end
    // Free-running mode: start at the direct load, stop after one instruction
    wb(1'h1, decode_pkg::REG_PC, 32'h6, 4'hF);
    wb(1'h1, decode_pkg::REG_CTRL, 32'h1, 4'hF);
    while (busy !== 1'h1) @(posedge clk);
    wb(1'h1, decode_pkg::REG_CTRL, 32'h0, 4'hF);
    while (busy !== 1'h0) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(busy, 1'h0);
    wb(1'h0, decode_pkg::REG_ACC, 32'h0, 4'hF);
    chk(q, 32'h5A);
    wb(1'h0, decode_pkg::REG_PC, 32'h0, 4'hF);
    chk(q, 32'h8);
    $display("Run mode test done");
    tally_and_finish();
  end
endmodule : two_word_instr_decode_addr_gen_tb
`default_nettype wire
